// ==== hlc_pkg.sv ====
package hlc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_DRIVE_LOOP = 8'h1b;
  localparam logic [7:0] ADDR_INPUT_LOOP = 8'h1c;
  localparam logic [7:0] DRIVE_LOOP_RST = 8'h93;
  localparam logic [7:0] INPUT_LOOP_RST = 8'hf5;
  localparam logic [7:0] DRIVE_LOOP_WMASK = 8'hbf;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BOOST_BIT = 7;
  localparam int BIAS_BIT = 5;
  localparam int DT_LSB = 0;
  localparam int DT_W = 5;
  localparam int SIGNED_BIT = 7;
  localparam int BRAKE_STAB_BIT = 6;
  localparam int SAMPLE_LSB = 4;
  localparam int BLANK_LSB = 2;
  localparam int IDISS_LSB = 0;
  localparam int FLD2_W = 2;
  localparam logic [DT_W-1:0] DT_MAX = 5'h1f;
  localparam logic [DT_W-1:0] DT_MIN = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LRA_STEP_NS = 100000;
  localparam int LRA_BASE_NS = 500000;
  localparam int ERM_STEP_NS = 200000;
  localparam int ERM_BASE_NS = 1000000;
  localparam int LRA_STEP_CYC = LRA_STEP_NS / CLK_PERIOD_NS;
  localparam int LRA_BASE_CYC = LRA_BASE_NS / CLK_PERIOD_NS;
  localparam int ERM_STEP_CYC = ERM_STEP_NS / CLK_PERIOD_NS;
  localparam int ERM_BASE_CYC = ERM_BASE_NS / CLK_PERIOD_NS;
  localparam int PERIOD_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // serial bus and amplitude
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [7:0] HALF_SCALE = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [3:0] {
    HLC_IDLE, HLC_ADDR, HLC_ADDR_ACK, HLC_PTR, HLC_PTR_ACK,
    HLC_WR, HLC_WR_ACK, HLC_RD, HLC_RD_ACK
  } hlc_i2c_state_e;

endpackage

// ==== hlc_sync3.sv ====
`timescale 1ns/1ps
module hlc_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pin side
  input wire logic pin_i,
  // filtered level
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // three stages, level moves once the last two agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_o <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end

endmodule

// ==== hlc_interval_timer.sv ====
`timescale 1ns/1ps
module hlc_interval_timer #(
  parameter int W = hlc_pkg::PERIOD_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // interval length in cycles
  input wire logic [W-1:0] period_cyc,
  // one pulse per interval
  output logic tick
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q >= period_cyc - W'(1)) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= 1'b0;
    end
  end

endmodule

// ==== hlc_loop_ctrl.sv ====
// Functional notes
// R01 - the drive-loop configuration register (boost, bias, drive time) sits at address 0x1B.
// R02 - the input and loop timing configuration register sits at address 0x1C.
// R03 - bit 7 of the drive-loop register, reset 1, raises loop gain during overdrive.
// R04 - bit 5 of the drive-loop register, reset 0, drives a 0.9 V common mode on the trigger pin.
// R05 - the host sets the bias bit only for analog input, never for PWM or trigger use.
// R06 - in resonant mode the drive time is field times 0.1 ms plus 0.5 ms.
// R07 - in resonant mode the field (reset 0x13) is only a start value, tracked in real time.
// R08 - the host programs the field near half the actuator period.
// R09 - in rotating-mass mode the field sets a back-EMF interval of field times 0.2 ms plus 1 ms.
// R10 - bit 7 of the second register, reset 1, picks input interpretation; 0 is unidirectional.
// R11 - in unidirectional mode braking comes only from feedback conditions.
// R12 - in unidirectional mode the whole input range is positive amplitude.
// R13 - in unidirectional mode 0% input gives no output and 50% gives half scale, linearly.
// R14 - the host uses unidirectional mode only in closed-loop operation.
// R15 - reserved bit 6 of the drive-loop register ignores writes and reads zero.
`timescale 1ns/1ps
module hlc_loop_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h2c,
  parameter int LRA_STEP_CYC = hlc_pkg::LRA_STEP_CYC,
  parameter int LRA_BASE_CYC = hlc_pkg::LRA_BASE_CYC,
  parameter int ERM_STEP_CYC = hlc_pkg::ERM_STEP_CYC,
  parameter int ERM_BASE_CYC = hlc_pkg::ERM_BASE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial register bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // loop environment
  input wire logic lra_mode,
  input wire logic phase_early,
  input wire logic phase_late,
  input wire logic feedback_brake_req,
  input wire logic [7:0] input_level,
  // loop controls
  output logic overdrive_gain_boost,
  output logic input_common_mode_bias,
  output logic signed_input_select,
  output logic brake_loop_gain_reduce,
  output logic [1:0] sample_time,
  output logic [1:0] blanking_time,
  output logic [1:0] current_dissipate_delay,
  output logic [4:0] drive_time_code,
  output logic drive_tick,
  // drive amplitude
  output logic [7:0] drive_magnitude,
  output logic drive_negative,
  output logic brake_en
);

  localparam int PW = hlc_pkg::PERIOD_W;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [PW-1:0] interval_of(input logic [4:0] code, input logic resonant_linear_actuator);
    logic [PW-1:0] c;
    c = PW'(code);
    if (resonant_linear_actuator) begin
      interval_of = PW'(c * PW'(LRA_STEP_CYC) + PW'(LRA_BASE_CYC)); // see R06
    end else begin
      interval_of = PW'(c * PW'(ERM_STEP_CYC) + PW'(ERM_BASE_CYC)); // see R09
    end
  endfunction

  logic [7:0] drive_loop_q;
  logic [7:0] input_loop_q;

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    if (a == hlc_pkg::ADDR_DRIVE_LOOP) begin
      read_byte = drive_loop_q & hlc_pkg::DRIVE_LOOP_WMASK; // see R15
    end else if (a == hlc_pkg::ADDR_INPUT_LOOP) begin
      read_byte = input_loop_q;
    end else begin
      read_byte = hlc_pkg::ZERO_BYTE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;

  hlc_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_i(scl_i),
    .level_o(scl_f)
  );

  hlc_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_i(sda_i),
    .level_o(sda_f)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign bus_stop = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave

  hlc_pkg::hlc_i2c_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic ack_on_q;
  logic master_ack_q;
  logic wr_en_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rx_byte;

  assign rx_byte = {shift_q[6:0], sda_f};

  // byte at the pointer, first bit goes out on the line
  logic [7:0] rd_byte;

  assign rd_byte = read_byte(ptr_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hlc_pkg::HLC_IDLE;
      bit_cnt_q <= hlc_pkg::BIT_FIRST;
      shift_q <= hlc_pkg::ZERO_BYTE;
      ptr_q <= hlc_pkg::ZERO_BYTE;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      master_ack_q <= 1'b0;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= hlc_pkg::ZERO_BYTE;
      wr_data_q <= hlc_pkg::ZERO_BYTE;
    end else begin
      wr_en_q <= 1'b0;
      sda_o <= 1'b0;
      if (bus_stop) begin
        state_q <= hlc_pkg::HLC_IDLE;
        sda_oe <= 1'b0;
        ack_on_q <= 1'b0;
      end else if (bus_start) begin
        state_q <= hlc_pkg::HLC_ADDR;
        bit_cnt_q <= hlc_pkg::BIT_FIRST;
        sda_oe <= 1'b0;
        ack_on_q <= 1'b0;
      end else begin
        unique case (state_q)
          hlc_pkg::HLC_IDLE: begin
          end
          hlc_pkg::HLC_ADDR, hlc_pkg::HLC_PTR, hlc_pkg::HLC_WR: begin
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == hlc_pkg::BIT_LAST) begin
                if (state_q == hlc_pkg::HLC_ADDR) begin
                  rw_q <= sda_f;
                  state_q <= (rx_byte[7:1] == DEV_ADDR) ? hlc_pkg::HLC_ADDR_ACK
                                                        : hlc_pkg::HLC_IDLE;
                end else if (state_q == hlc_pkg::HLC_PTR) begin
                  ptr_q <= rx_byte;
                  state_q <= hlc_pkg::HLC_PTR_ACK;
                end else begin
                  wr_en_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= rx_byte;
                  ptr_q <= ptr_q + 8'h01;
                  state_q <= hlc_pkg::HLC_WR_ACK;
                end
              end
            end
          end
          hlc_pkg::HLC_ADDR_ACK, hlc_pkg::HLC_PTR_ACK, hlc_pkg::HLC_WR_ACK: begin
            if (scl_fall && !ack_on_q) begin
              sda_oe <= 1'b1;
              ack_on_q <= 1'b1;
            end else if (scl_fall) begin
              ack_on_q <= 1'b0;
              bit_cnt_q <= hlc_pkg::BIT_FIRST;
              if (state_q == hlc_pkg::HLC_ADDR_ACK && rw_q) begin
                shift_q <= rd_byte;
                sda_oe <= ~rd_byte[7];
                state_q <= hlc_pkg::HLC_RD;
              end else begin
                sda_oe <= 1'b0;
                state_q <= (state_q == hlc_pkg::HLC_ADDR_ACK) ? hlc_pkg::HLC_PTR
                                                              : hlc_pkg::HLC_WR;
              end
            end
          end
          hlc_pkg::HLC_RD: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == hlc_pkg::BIT_LAST) begin
                ptr_q <= ptr_q + 8'h01;
                state_q <= hlc_pkg::HLC_RD_ACK;
              end
            end else if (scl_fall) begin
              sda_oe <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          hlc_pkg::HLC_RD_ACK: begin
            if (scl_fall && !ack_on_q) begin
              sda_oe <= 1'b0;
              ack_on_q <= 1'b1;
            end else if (scl_rise) begin
              master_ack_q <= ~sda_f;
            end else if (scl_fall) begin
              ack_on_q <= 1'b0;
              bit_cnt_q <= hlc_pkg::BIT_FIRST;
              if (master_ack_q) begin
                shift_q <= rd_byte;
                sda_oe <= ~rd_byte[7];
                state_q <= hlc_pkg::HLC_RD;
              end else begin
                state_q <= hlc_pkg::HLC_IDLE;
              end
            end
          end
          default: begin
            state_q <= hlc_pkg::HLC_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_loop_q <= hlc_pkg::DRIVE_LOOP_RST & hlc_pkg::DRIVE_LOOP_WMASK;
      input_loop_q <= hlc_pkg::INPUT_LOOP_RST;
    end else if (wr_en_q) begin
      if (wr_addr_q == hlc_pkg::ADDR_DRIVE_LOOP) begin // see R01
        drive_loop_q <= wr_data_q & hlc_pkg::DRIVE_LOOP_WMASK; // see R15
      end
      if (wr_addr_q == hlc_pkg::ADDR_INPUT_LOOP) begin // see R02
        input_loop_q <= wr_data_q;
      end
    end
  end

  assign overdrive_gain_boost = drive_loop_q[hlc_pkg::BOOST_BIT]; // see R03
  assign input_common_mode_bias = drive_loop_q[hlc_pkg::BIAS_BIT]; // see R04
  assign signed_input_select = input_loop_q[hlc_pkg::SIGNED_BIT]; // see R10
  assign brake_loop_gain_reduce = input_loop_q[hlc_pkg::BRAKE_STAB_BIT];
  assign sample_time = input_loop_q[hlc_pkg::SAMPLE_LSB +: hlc_pkg::FLD2_W];
  assign blanking_time = input_loop_q[hlc_pkg::BLANK_LSB +: hlc_pkg::FLD2_W];
  assign current_dissipate_delay = input_loop_q[hlc_pkg::IDISS_LSB +: hlc_pkg::FLD2_W];

  ////////////////////////////////////////////////////////////////////////////
  // drive time tracking

  logic [4:0] field_dt;
  logic [PW-1:0] period_q;

  assign field_dt = drive_loop_q[hlc_pkg::DT_LSB +: hlc_pkg::DT_W];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_time_code <= hlc_pkg::DRIVE_LOOP_RST[hlc_pkg::DT_LSB +: hlc_pkg::DT_W];
    end else if (!lra_mode || (wr_en_q && wr_addr_q == hlc_pkg::ADDR_DRIVE_LOOP)) begin
      drive_time_code <= lra_mode ? wr_data_q[hlc_pkg::DT_LSB +: hlc_pkg::DT_W]
                                  : field_dt; // see R09
    end else if (phase_late && drive_time_code != hlc_pkg::DT_MAX) begin
      drive_time_code <= drive_time_code + 5'h01; // see R07
    end else if (phase_early && !phase_late && drive_time_code != hlc_pkg::DT_MIN) begin
      drive_time_code <= drive_time_code - 5'h01; // see R07
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= PW'(LRA_BASE_CYC);
    end else begin
      period_q <= interval_of(drive_time_code, lra_mode); // see R06 R09
    end
  end

  hlc_interval_timer #(.W(PW)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .period_cyc(period_q),
    .tick(drive_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // input interpretation

  logic [7:0] offs;

  assign offs = (input_level >= hlc_pkg::HALF_SCALE) ? input_level - hlc_pkg::HALF_SCALE
                                                    : hlc_pkg::HALF_SCALE - input_level;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_magnitude <= hlc_pkg::ZERO_BYTE;
      drive_negative <= 1'b0;
      brake_en <= 1'b0;
    end else if (!signed_input_select) begin
      drive_magnitude <= input_level; // see R12 R13
      drive_negative <= 1'b0;
      brake_en <= feedback_brake_req; // see R11
    end else begin
      drive_magnitude <= (offs[7]) ? 8'hff : {offs[6:0], 1'b0};
      drive_negative <= input_level < hlc_pkg::HALF_SCALE;
      brake_en <= feedback_brake_req | (input_level < hlc_pkg::HALF_SCALE);
    end
  end

endmodule

// ==== hlc_loop_ctrl_props.sv ====
`timescale 1ns/1ps
module hlc_loop_ctrl_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // loop environment
  input wire logic lra_mode,
  input wire logic phase_early,
  input wire logic phase_late,
  input wire logic feedback_brake_req,
  input wire logic [7:0] input_level,
  // loop controls
  input wire logic overdrive_gain_boost,
  input wire logic input_common_mode_bias,
  input wire logic signed_input_select,
  input wire logic sda_oe,
  input wire logic [4:0] drive_time_code,
  input wire logic drive_tick,
  // amplitude
  input wire logic [7:0] drive_magnitude,
  input wire logic drive_negative,
  input wire logic brake_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_vals: assert property ($rose(rst_n) |-> overdrive_gain_boost &&
    !input_common_mode_bias && signed_input_select && drive_time_code == 5'h13)
    else $error("bad value after reset");
  a_uni_mag: assert property ($past(!signed_input_select) |->
    drive_magnitude == $past(input_level)) else $error("unidirectional magnitude wrong");
  a_uni_pos: assert property ($past(!signed_input_select) |-> !drive_negative)
    else $error("negative drive in unidirectional mode");
  a_uni_brake: assert property ($past(!signed_input_select) |->
    brake_en == $past(feedback_brake_req)) else $error("braking not from feedback");
  a_code_up: assert property (lra_mode && phase_late && drive_time_code != 5'h1f |=>
    drive_time_code == $past(drive_time_code) + 5'h01) else $error("code did not step up");
  a_code_down: assert property (lra_mode && phase_early && !phase_late &&
    drive_time_code != 5'h00 |=> drive_time_code == $past(drive_time_code) - 5'h01)
    else $error("code did not step down");
  a_code_sat: assert property (lra_mode && (phase_late && drive_time_code == 5'h1f ||
    phase_early && !phase_late && drive_time_code == 5'h00) |=> $stable(drive_time_code))
    else $error("code wrapped");
  a_tick_pulse: assert property (drive_tick |=> !drive_tick [*8])
    else $error("interval tick too close");
  c_tick: cover property (drive_tick);
  c_uni: cover property (!signed_input_select);
  c_ack: cover property ($rose(sda_oe));
endmodule
bind hlc_loop_ctrl hlc_loop_ctrl_props u_props (.mclk(mclk), .rst_n(rst_n),
  .lra_mode(lra_mode), .phase_early(phase_early), .phase_late(phase_late),
  .feedback_brake_req(feedback_brake_req), .input_level(input_level),
  .overdrive_gain_boost(overdrive_gain_boost), .sda_oe(sda_oe),
  .input_common_mode_bias(input_common_mode_bias), .signed_input_select(signed_input_select),
  .drive_time_code(drive_time_code), .drive_tick(drive_tick),
  .drive_magnitude(drive_magnitude), .drive_negative(drive_negative), .brake_en(brake_en));

// ==== hlc_i2c_host.sv ====
`timescale 1ns/1ps
module hlc_i2c_host (
  // clock
  input wire logic mclk,
  // bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (10) @(posedge mclk);
    #1;
  endtask
  // data moves only well after the clock falls
  task automatic lo();
    scl = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    lo();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  task automatic bit_out(input logic b);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    lo();
  endtask
  task automatic get(output logic b);
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    b = sda;
    lo();
  endtask
  task automatic put(input logic [7:0] v, output logic k);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    get(k);
    k = !k;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
    output logic ok);
    logic k0, k1, k2;
    start();
    put({a, 1'b0}, k0);
    put(p, k1);
    put(v, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v,
    output logic ok);
    logic k0, k1, k2;
    start();
    put({a, 1'b0}, k0);
    put(p, k1);
    start();
    put({a, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) get(v[i]);
    bit_out(1'b1);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

// ==== tb_haptic_loop_control_regs.sv ====
`timescale 1ns/1ps
module tb_haptic_loop_control_regs;
  typedef struct packed {
    logic sel;
    logic [7:0] lvl;
    logic req;
    logic [7:0] mag;
    logic neg;
    logic brk;
  } hlc_row_s;
  localparam hlc_row_s ROWS [6] = '{
    '{1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0},
    '{1'b0, 8'h80, 1'b0, 8'h80, 1'b0, 1'b0},
    '{1'b0, 8'hff, 1'b1, 8'hff, 1'b0, 1'b1},
    '{1'b0, 8'h40, 1'b1, 8'h40, 1'b0, 1'b1},
    '{1'b1, 8'h40, 1'b0, 8'h80, 1'b1, 1'b1},
    '{1'b1, 8'hc0, 1'b0, 8'h80, 1'b0, 1'b0}};
  logic mclk, rst_n, scl, sda_low, sda_oe, sda_o, lra_mode, pe, pl, req, ok;
  logic boost, bias, sel, stab, tick, neg, brk;
  logic [1:0] st, bt, cd;
  logic [4:0] code;
  logic [7:0] lvl, mag, d;
  logic [15:0] n;
  int fails, tests_run;
  wire logic sda = !(sda_low || (sda_oe && !sda_o));
  hlc_loop_ctrl #(.LRA_STEP_CYC(10), .LRA_BASE_CYC(50), .ERM_STEP_CYC(20),
    .ERM_BASE_CYC(100)) u_dut (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .lra_mode(lra_mode), .phase_early(pe),
    .phase_late(pl), .feedback_brake_req(req), .input_level(lvl),
    .overdrive_gain_boost(boost), .input_common_mode_bias(bias),
    .signed_input_select(sel), .brake_loop_gain_reduce(stab), .sample_time(st),
    .blanking_time(bt), .current_dissipate_delay(cd), .drive_time_code(code),
    .drive_tick(tick), .drive_magnitude(mag), .drive_negative(neg), .brake_en(brk));
  hlc_i2c_host u_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tk();
    @(posedge mclk);
    #1;
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    u_host.rd(7'h2c, p, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic wrc(input logic [7:0] p, input logic [7:0] v);
    u_host.wr(7'h2c, p, v, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic gap();
    int i;
    for (int k = 0; k < 2; k++) begin
      i = 0;
      n = 16'h0000;
      while (tick !== 1'b1 && i < 3000) begin
        tk();
        i++;
      end
      do begin
        tk();
        n++;
      end while (tick !== 1'b1 && n < 16'd3000);
      if (i >= 3000 || n >= 16'd3000) begin
        fails++;
        summarize();
      end
    end
  endtask
  task automatic pulse(input logic early);
    pe = early;
    pl = !early;
    tk();
    pe = 1'b0;
    pl = 1'b0;
    tk();
    tk();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst_n, lra_mode, pe, pl, req, lvl, fails, tests_run} = '0;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (10) tk();
    chk({15'h0000, boost}, 16'h0001);
    chk({15'h0000, bias}, 16'h0000);
    chk({15'h0000, sel}, 16'h0001);
    chk({11'h000, code}, 16'h0013);
    chk({9'h000, stab, st, bt, cd}, 16'h0075);
    rdc(8'h1b, 8'h93);
    rdc(8'h1c, 8'hf5);
    $display("test reset done");
    wrc(8'h1b, 8'hff);
    rdc(8'h1b, 8'hbf);
    chk({14'h0000, boost, bias}, 16'h0003);
    wrc(8'h1b, 8'h40);
    rdc(8'h1b, 8'h00);
    chk({14'h0000, boost, bias}, 16'h0000);
    chk({11'h000, code}, 16'h0000);
    rdc(8'h1d, 8'h00);
    u_host.wr(7'h2d, 8'h1b, 8'hff, ok);
    chk({15'h0000, ok}, 16'h0000);
    rdc(8'h1b, 8'h00);
    wrc(8'h1c, 8'h4a);
    rdc(8'h1c, 8'h4a);
    chk({9'h000, stab, st, bt, cd}, 16'h004a);
    chk({15'h0000, sel}, 16'h0000);
    $display("test registers done");
    for (int r = 0; r < 6; r++) begin
      if (ROWS[r].sel !== sel) wrc(8'h1c, {ROWS[r].sel, 7'h75});
      lvl = ROWS[r].lvl;
      req = ROWS[r].req;
      tk();
      tk();
      chk({6'h00, mag, neg, brk}, {6'h00, ROWS[r].mag, ROWS[r].neg, ROWS[r].brk});
    end
    $display("test amplitude done");
    wrc(8'h1b, 8'h02);
    gap();
    chk(n, 16'd140);
    lra_mode = 1'b1;
    wrc(8'h1b, 8'h03);
    gap();
    chk(n, 16'd80);
    pulse(1'b0);
    chk({11'h000, code}, 16'h0004);
    rdc(8'h1b, 8'h03);
    wrc(8'h1b, 8'h1f);
    pulse(1'b0);
    chk({11'h000, code}, 16'h001f);
    wrc(8'h1b, 8'h00);
    pulse(1'b1);
    chk({11'h000, code}, 16'h0000);
    $display("test drive time done");
    rst_n = 1'b0;
    tk();
    rst_n = 1'b1;
    repeat (4) tk();
    chk({11'h000, code}, 16'h0013);
    chk({15'h0000, sel}, 16'h0001);
    rdc(8'h1b, 8'h93);
    rdc(8'h1c, 8'hf5);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
